/* File: rtl/wdt_defines.vh */
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH
`define WDT_OFF_CTRL     4'h0
`define WDT_OFF_RELOAD   4'h1
`define WDT_OFF_VALUE    4'h2
`define WDT_OFF_STATUS   4'h3
`define WDT_OFF_CLEAR    4'h4
`define WDT_OFF_LOCK     4'h5
`define WDT_CTRL_EN      0
`define WDT_CTRL_INTEN   1
`define WDT_CTRL_RSTEN   2
`define WDT_CTRL_STALL   3
`define WDT_ST_RAW       0
`define WDT_ST_MASKED    1
`define WDT_ST_LOCKED    2
`define WDT_ST_RUNNING   3
`define WDT_ST_RESET     4
`define WDT_LOCK_KEY     32'h1ACCE551
`define WDT_RELOAD_RST   32'hFFFFFFFF
`define WDT_RESP_OKAY    2'h0
`define WDT_RESP_SLVERR  2'h2
`endif

/* File: rtl/wdt_sync.v */
`timescale 1ns/1ps
module wdt_sync (
  input  wire aclk,
  input  wire aresetn,
  input  wire d,
  output reg  q
);
  reg meta;
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

/* File: rtl/wdt_counter.v */
`timescale 1ns/1ps
`include "wdt_defines.vh"
module wdt_counter #(
  parameter WIDTH = 32
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             run,
  input  wire             hold,
  input  wire             load,
  input  wire [WIDTH-1:0] load_value,
  output reg  [WIDTH-1:0] count,
  output reg              expire
);
  // Zero reached: pulse and refill in the same edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      count  <= `WDT_RELOAD_RST;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (load) begin
        count <= load_value;
      end else if (run && !hold) begin
        if (count == {WIDTH{1'b0}}) begin
          count  <= load_value;
          expire <= 1'b1;
        end else begin
          count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

/* File: rtl/wdt_top.v */
`timescale 1ns/1ps
`include "wdt_defines.vh"
module wdt_top #(
  parameter WIDTH = 32
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        debug_halt,
  output reg         irq,
  output reg         reset_request
);
  reg              enable;
  reg              int_enable;
  reg              reset_enable;
  reg              stall_enable;
  reg              locked;
  reg              raw_int;
  reg  [WIDTH-1:0] reload_value;
  reg              aw_held;
  reg              w_held;
  reg  [31:0]      aw_addr;
  reg  [31:0]      w_data;
  reg  [3:0]       w_strb;
  wire             halt_sync;
  wire [WIDTH-1:0] count;
  wire             expire;
  reg              cnt_load;
  reg  [WIDTH-1:0] cnt_load_value;
  reg              wr_go;
  reg  [3:0]       wr_idx;
  reg              wr_ok;
  reg              wr_cfg;
  reg              clr_go;
  reg              zero_reload;
  reg              next_raw;
  reg              next_int_en;

  function [3:0] reg_index;
    input [31:0] addr;
    begin
      reg_index = addr[5:2];
    end
  endfunction

  function addr_valid;
    input [31:0] addr;
    begin
      addr_valid = (addr[31:6] == 26'h0) && (addr[5:2] <= `WDT_OFF_LOCK);
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  wdt_sync u_halt_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (debug_halt),
    .q       (halt_sync)
  );

  wdt_counter #(
    .WIDTH (WIDTH)
  ) u_counter (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .run        (enable),
    .hold       (stall_enable & halt_sync),
    .load       (cnt_load),
    .load_value (cnt_load_value),
    .count      (count),
    .expire     (expire)
  );

  // Write decode; fires once both address and data are held
  always @* begin
    wr_go          = aw_held && w_held && !s_axi_bvalid;
    wr_idx         = reg_index(aw_addr);
    wr_ok          = addr_valid(aw_addr);
    wr_cfg         = wr_go && wr_ok && !locked;
    clr_go         = wr_go && wr_ok && (wr_idx == `WDT_OFF_CLEAR);
    cnt_load       = 1'b0;
    cnt_load_value = reload_value;
    zero_reload    = 1'b0;
    if (wr_cfg && wr_idx == `WDT_OFF_RELOAD) begin
      cnt_load_value = merge(reload_value, w_data, w_strb);
      cnt_load       = enable;
      zero_reload    = (cnt_load_value == {WIDTH{1'b0}});
    end else if (clr_go && raw_int && enable) begin
      cnt_load = 1'b1;
    end
    // Set wins over a clear in the same edge
    next_raw = raw_int;
    if ((expire && !raw_int) || zero_reload) begin
      next_raw = 1'b1;
    end else if (clr_go) begin
      next_raw = 1'b0;
    end
    // Irq tracks the mask as it will stand after this edge
    next_int_en = int_enable;
    if (wr_cfg && wr_idx == `WDT_OFF_CTRL && w_strb[0] &&
        (w_data[`WDT_CTRL_EN] || w_data[`WDT_CTRL_INTEN])) begin
      next_int_en = 1'b1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `WDT_RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 32'h0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration and lock state
  always @(posedge aclk) begin
    if (!aresetn) begin
      enable       <= 1'b0;
      int_enable   <= 1'b0;
      reset_enable <= 1'b0;
      stall_enable <= 1'b0;
      locked       <= 1'b0;
      reload_value <= `WDT_RELOAD_RST;
    end else begin
      if (wr_cfg && wr_idx == `WDT_OFF_CTRL && w_strb[0]) begin
        // Enable is sticky; only reset stops a started watchdog
        if (w_data[`WDT_CTRL_EN]) begin
          enable     <= 1'b1;
          int_enable <= 1'b1;
        end
        if (w_data[`WDT_CTRL_INTEN]) begin
          int_enable <= 1'b1;
        end
        reset_enable <= w_data[`WDT_CTRL_RSTEN];
        if (w_data[`WDT_CTRL_STALL]) begin
          stall_enable <= 1'b1;
        end
      end
      if (wr_cfg && wr_idx == `WDT_OFF_RELOAD) begin
        reload_value <= cnt_load_value;
      end
      if (wr_go && wr_ok && wr_idx == `WDT_OFF_LOCK) begin
        locked <= (w_data != `WDT_LOCK_KEY);
      end
    end
  end

  // Timeout status, second timeout and outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      raw_int       <= 1'b0;
      reset_request <= 1'b0;
      irq           <= 1'b0;
    end else begin
      raw_int <= next_raw;
      if (expire && raw_int && reset_enable) begin
        reset_request <= 1'b1;
      end
      irq <= next_int_en && next_raw;
    end
  end

  // Reads answer on the same edge that takes the address
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `WDT_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= addr_valid(s_axi_araddr) ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
        s_axi_rdata  <= 32'h0;
        case (reg_index(s_axi_araddr))
          `WDT_OFF_CTRL: begin
            s_axi_rdata[`WDT_CTRL_EN]    <= enable;
            s_axi_rdata[`WDT_CTRL_INTEN] <= int_enable;
            s_axi_rdata[`WDT_CTRL_RSTEN] <= reset_enable;
            s_axi_rdata[`WDT_CTRL_STALL] <= stall_enable;
          end
          `WDT_OFF_RELOAD: s_axi_rdata <= reload_value;
          `WDT_OFF_VALUE:  s_axi_rdata <= count;
          `WDT_OFF_STATUS: begin
            s_axi_rdata[`WDT_ST_RAW]     <= raw_int;
            s_axi_rdata[`WDT_ST_MASKED]  <= raw_int & int_enable;
            s_axi_rdata[`WDT_ST_LOCKED]  <= locked;
            s_axi_rdata[`WDT_ST_RUNNING] <= enable;
            s_axi_rdata[`WDT_ST_RESET]   <= reset_request;
          end
          `WDT_OFF_LOCK: s_axi_rdata <= {31'h0, locked};
          default: s_axi_rdata <= 32'h0;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

/* File: tb/wdt_properties.sv */
`timescale 1ns/1ps
module wdt_properties (
  input wire        aclk,
  input wire        aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire        irq,
  input wire        reset_request
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  a_w_pulse: assert property (s_axi_wready |=> !s_axi_wready)
    else $error("wready longer than one cycle");
  a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready longer than one cycle");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata))
    else $error("read answer changed early");
  a_clear_drops_irq: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && s_axi_awaddr == 32'h10 |-> ##2 !irq)
    else $error("irq still high after clear");
  a_reset_sticky: assert property (reset_request |=> reset_request)
    else $error("reset request dropped");
  a_reset_after_irq: assert property ($rose(reset_request) |-> $past(irq))
    else $error("reset request without pending irq");
endmodule
bind wdt_top wdt_properties u_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .irq, .reset_request);

/* File: tb/wdt_partner.sv */
`timescale 1ns/1ps
module wdt_partner (
  input  wire  aclk,
  input  wire  aresetn,
  input  wire  irq,
  input  wire  reset_request,
  output int   entries,
  output logic reset_seen
);
  logic irq_d;
  // Each rising request is one handler entry; a late clear would show a second
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_d <= 1'b0;
      entries <= 0;
      reset_seen <= 1'b0;
    end else begin
      irq_d <= irq;
      if (irq && !irq_d) entries <= entries + 1;
      if (reset_request) reset_seen <= 1'b1;
    end
  end
endmodule

/* File: tb/watchdog_timer_core_tb.sv */
`timescale 1ns/1ps
`include "wdt_defines.vh"
module watchdog_timer_core_tb;
  localparam logic [31:0] CTRL = 32'h0, RLD = 32'h4, VAL = 32'h8, ST = 32'hC;
  localparam logic [31:0] CLR = 32'h10, LCK = 32'h14;
  logic aclk = 1'b0, aresetn = 1'b0, debug_halt = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, v, v2;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, reset_seen;
  logic [1:0] rresp_seen;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire reset_request;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int bad_count = 0, compares = 0, entries;
  always #12.5 aclk = ~aclk;
  wdt_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .debug_halt, .irq, .reset_request);
  wdt_partner partner (.aclk, .aresetn, .irq, .reset_request, .entries, .reset_seen);
  task automatic test_done;
    if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'h0, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    rresp_seen = s_axi_rresp;
  endtask
  task automatic await(input bit rst, input int lim);
    repeat (lim) begin
      @(posedge aclk);
      if ((rst ? reset_request : irq) === 1'b1) break;
    end
    chk(rst ? "reset_request" : "irq", 32'h1, {31'h0, rst ? reset_request : irq});
  endtask
  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  task automatic t_idle;
    rd(RLD, v);
    chk("reload", `WDT_RELOAD_RST, v);
    rd(ST, v);
    chk("status", 32'h0, v & 32'h1F);
    rd(32'h3C, v);
    chk("unmapped", {30'h0, `WDT_RESP_SLVERR}, {30'h0, rresp_seen});
  endtask
  task automatic t_enable;
    wr(CTRL, 32'h1);
    rd(ST, v);
    chk("running", 32'h8, v & 32'h1F);
    wr(RLD, 32'd20);
    rd(VAL, v);
    chk("counting", 32'h1, {31'h0, v < 32'd20});
    await(1'b0, 40);
    rd(ST, v);
    chk("raised", 32'hB, v & 32'h1F);
    wr(CLR, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    rd(ST, v);
    chk("cleared", 32'h8, v & 32'h1F);
    rd(VAL, v);
    chk("reloaded", 32'h1, {31'h0, v > 32'd12});
    chk("entries", 32'h1, 32'(entries));
  endtask
  task automatic t_lock;
    wr(LCK, 32'h0);
    rd(ST, v);
    chk("locked", 32'h4, v & 32'h4);
    wr(RLD, 32'd5);
    wr(CTRL, 32'h4);
    rd(RLD, v);
    chk("reload", 32'd20, v);
    repeat (60) @(posedge aclk);
    chk("reset_request", 32'h0, {31'h0, reset_request});
    wr(LCK, `WDT_LOCK_KEY);
    rd(ST, v);
    chk("unlocked", 32'h0, v & 32'h4);
  endtask
  task automatic t_second;
    wr(RLD, 32'd1000);
    wr(CLR, 32'h0);
    wr(CTRL, 32'h5);
    wr(CTRL, 32'h1);
    wr(RLD, 32'd10);
    rd(VAL, v);
    chk("loaded", 32'h1, {31'h0, v <= 32'd10});
    repeat (40) @(posedge aclk);
    chk("reset_request", 32'h0, {31'h0, reset_request});
    wr(CTRL, 32'h4);
    await(1'b1, 30);
    @(posedge aclk);
    chk("reset_seen", 32'h1, {31'h0, reset_seen});
  endtask
  task automatic t_stall;
    wr(RLD, 32'h0);
    rd(ST, v);
    chk("raw only", 32'h1, v & 32'h1F);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(CTRL, 32'h2);
    rd(ST, v);
    chk("masked", 32'h3, v & 32'h1F);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(CLR, 32'h0);
    wr(CTRL, 32'h9);
    debug_halt <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(VAL, v);
    rd(VAL, v2);
    chk("halted", v, v2);
    debug_halt <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(VAL, v2);
    chk("resumed", 32'h1, {31'h0, v2 < v});
    wr(RLD, 32'h0);
    await(1'b0, 4);
  endtask
  initial begin
    do_reset;
    t_idle;
    t_enable;
    t_lock;
    t_second;
    do_reset;
    t_stall;
    test_done;
  end
  initial begin
    repeat (3000) @(posedge aclk);
    bad_count++;
    test_done;
  end
endmodule
